// ==== vtpc_pkg.sv ====
// Package for the VT de-mapper performance counter and event mask bank
package vtpc_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets on the AXI4-Lite bus
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  OFF_BIP_HI      = 8'h00;
  localparam logic [7:0]  OFF_BIP_LO      = 8'h04;
  localparam logic [7:0]  OFF_REI_HI      = 8'h08;
  localparam logic [7:0]  OFF_REI_LO      = 8'h0C;
  localparam logic [7:0]  OFF_MASK        = 8'h10;

  // ----------------------------------------------------------------
  // Field positions in the event mask / status register
  // ----------------------------------------------------------------
  localparam int          MB_CHAN_EN      = 7;
  localparam int          MB_SIZE         = 6;
  localparam int          MB_LOPV         = 5;
  localparam int          MB_LABEL        = 4;
  localparam int          MB_OVF          = 3;
  localparam int          MB_AIS_FAIL_EN  = 2;
  localparam int          MB_AIS_FAIL     = 1;
  localparam int          MB_AIS_DEF      = 0;
  localparam logic [7:0]  MASK_RW_BITS    = 8'hF5;
  localparam logic [7:0]  MASK_RESET      = 8'h00;

  // ----------------------------------------------------------------
  // Counter widths and reset values
  // ----------------------------------------------------------------
  localparam int          ERR_CNT_W       = 12;
  localparam int          PTR_CNT_W       = 4;
  localparam logic [11:0] ERR_CNT_RESET   = 12'h000;
  localparam logic [3:0]  PTR_CNT_RESET   = 4'h0;
  localparam logic [11:0] CLR_HI_NIBBLE   = 12'hF00;
  localparam logic [11:0] CLR_LO_BYTE     = 12'h0FF;

  // ----------------------------------------------------------------
  // AXI responses
  // ----------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY       = 2'b00;
  localparam logic [1:0]  RESP_SLVERR     = 2'b10;

  // ----------------------------------------------------------------
  // Timing: 10 MHz clock, millisecond tick, AIS-V failure times
  // ----------------------------------------------------------------
  localparam int          CLK_HZ          = 10_000_000;
  localparam int          TICK_TIME_MS    = 1;
  localparam int          TICK_CYCLES     = (CLK_HZ / 1000) * TICK_TIME_MS;
  localparam real         AIS_SET_TIME_S  = 2.5;
  localparam real         AIS_CLR_TIME_S  = 10.0;
  localparam int          AIS_SET_TICKS   = 2500;
  localparam int          AIS_CLR_TICKS   = 10000;
  localparam int          AIS_TICK_W      = 14;

  // AIS-V failure declaration state
  typedef enum logic [1:0]
  {
    AIS_IDLE = 2'b01,
    AIS_FAIL = 2'b10
  } vtpc_ais_e;

endpackage : vtpc_pkg

// ==== vtpc_sat_cnt.sv ====
// Saturating event counter with per-bit clear for clear-on-read fields
`timescale 1ns/1ps
`default_nettype none
module vtpc_sat_cnt #(
  parameter int W = 12
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         inc,
  input  wire logic [W-1:0] clr_mask,
  output var  logic [W-1:0] cnt
);

  logic [W-1:0] base;

  // Cleared bits drop first, so an event in the reading cycle lands in the new interval
  always_comb
  begin
    base = cnt & ~clr_mask;
  end

  // ----------------------------------------------------------------
  // Count, hold at all ones instead of wrapping
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt <= '0;
    else if (inc && (base != {W{1'b1}}))
      cnt <= base + {{(W-1){1'b0}}, 1'b1};
    else
      cnt <= base;
  end

endmodule : vtpc_sat_cnt
`default_nettype wire

// ==== vtpc_regs.sv ====
// VT de-mapper performance counters and event mask bank with AXI4-Lite slave
//
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module vtpc_regs
  import vtpc_pkg::*;
#(
  parameter int TICK_CYC  = TICK_CYCLES,
  parameter int SET_TICKS = AIS_SET_TICKS,
  parameter int CLR_TICKS = AIS_CLR_TICKS
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              bip2_err_evt,
  input  wire logic              rei_evt,
  input  wire logic              ptr_inc_evt,
  input  wire logic              ptr_dec_evt,
  input  wire logic              size_err_decl,
  input  wire logic              lopv_decl,
  input  wire logic              label_chg_decl,
  input  wire logic              aisv_defect_decl,
  input  wire logic              es_overflow_evt,
  input  wire logic              rfiv_cause_masked,
  input  wire logic              rdiv_cause_masked,
  input  wire logic              aps_chg_cause_masked,
  output var  logic              vt_error_event,
  output var  logic              aisv_failure
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic              aw_held_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic              w_held_reg;
  logic [31:0]       w_data_reg;
  logic              w_strb0_reg;
  logic              do_write;
  logic              rd_take;
  logic [11:0]       bip_cnt;
  logic [11:0]       rei_cnt;
  logic [3:0]        inc_cnt;
  logic [3:0]        dec_cnt;
  logic [11:0]       bip_clr;
  logic [11:0]       rei_clr;
  logic [3:0]        inc_clr;
  logic [3:0]        dec_clr;
  logic [7:0]        mask_reg;
  logic              ovf_reg;
  logic              mask_wr;
  logic [31:0]       tick_cnt_reg;
  logic              tick;
  logic [AIS_TICK_W-1:0] ais_cnt_reg;
  vtpc_ais_e         ais_state_reg;
  logic [7:0]        mask_view;

  // Address is one of ours
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == OFF_BIP_HI) || (a == OFF_BIP_LO) || (a == OFF_REI_HI)
             || (a == OFF_REI_LO) || (a == OFF_MASK);
  endfunction : is_mapped

  // Assembled mask/status byte as software sees it
  always_comb
  begin
    mask_view               = mask_reg & MASK_RW_BITS;
    mask_view[MB_OVF]       = ovf_reg;
    mask_view[MB_AIS_FAIL]  = aisv_failure;
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  // Address and data are taken independently; nothing new until B is gone
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign do_write      = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign mask_wr       = do_write && (aw_addr_reg == OFF_MASK) && w_strb0_reg;

  // Holding registers for address and data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_held_reg  <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_strb0_reg <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      else if (do_write)
        aw_held_reg <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg  <= 1'b1;
        w_data_reg  <= s_axi_wdata;
        w_strb0_reg <= s_axi_wstrb[0];
      end
      else if (do_write)
        w_held_reg <= 1'b0;
    end
  end

  // Write response; counters accept writes silently, unmapped gets SLVERR
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= is_mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_take       = s_axi_arvalid && s_axi_arready;

  // Read data registered in the same edge that clears the counter byte
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (rd_take)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        OFF_BIP_HI: s_axi_rdata <= {24'h000000, inc_cnt, bip_cnt[11:8]};
        OFF_BIP_LO: s_axi_rdata <= {24'h000000, bip_cnt[7:0]};
        OFF_REI_HI: s_axi_rdata <= {24'h000000, dec_cnt, rei_cnt[11:8]};
        OFF_REI_LO: s_axi_rdata <= {24'h000000, rei_cnt[7:0]};
        OFF_MASK:   s_axi_rdata <= {24'h000000, mask_view};
        default:    s_axi_rdata <= 32'h0000_0000;
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Clear-on-read counters
  // ----------------------------------------------------------------
  // Each byte clears only on its own read, so a split read never loses counts
  always_comb
  begin
    bip_clr = 12'h000;
    rei_clr = 12'h000;
    inc_clr = 4'h0;
    dec_clr = 4'h0;
    if (rd_take && (s_axi_araddr == OFF_BIP_HI))
    begin
      bip_clr = CLR_HI_NIBBLE;
      inc_clr = 4'hF;
    end
    if (rd_take && (s_axi_araddr == OFF_BIP_LO))
      bip_clr = CLR_LO_BYTE;
    if (rd_take && (s_axi_araddr == OFF_REI_HI))
    begin
      rei_clr = CLR_HI_NIBBLE;
      dec_clr = 4'hF;
    end
    if (rd_take && (s_axi_araddr == OFF_REI_LO))
      rei_clr = CLR_LO_BYTE;
  end

  // BIP-2 error count, saturating
  vtpc_sat_cnt #(.W(ERR_CNT_W)) u_bip (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .inc      (bip2_err_evt),
    .clr_mask (bip_clr),
    .cnt      (bip_cnt)
  );

  // REI-V event count, saturating
  vtpc_sat_cnt #(.W(ERR_CNT_W)) u_rei (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .inc      (rei_evt),
    .clr_mask (rei_clr),
    .cnt      (rei_cnt)
  );

  // Pointer increment count
  vtpc_sat_cnt #(.W(PTR_CNT_W)) u_inc (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .inc      (ptr_inc_evt),
    .clr_mask (inc_clr),
    .cnt      (inc_cnt)
  );

  // Pointer decrement count
  vtpc_sat_cnt #(.W(PTR_CNT_W)) u_dec (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .inc      (ptr_dec_evt),
    .clr_mask (dec_clr),
    .cnt      (dec_cnt)
  );

  // ----------------------------------------------------------------
  // Event mask register and overflow latch
  // ----------------------------------------------------------------
  // Writable mask bits; bits 3 and 1 are not stored here
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mask_reg <= MASK_RESET;
    else if (mask_wr)
      mask_reg <= w_data_reg[7:0] & MASK_RW_BITS;
  end

  // Overflow latch: a new overflow beats a write-one clear in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ovf_reg <= 1'b0;
    else if (es_overflow_evt)
      ovf_reg <= 1'b1;
    else if (mask_wr && w_data_reg[MB_OVF])
      ovf_reg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // AIS-V failure timing
  // ----------------------------------------------------------------
  // Millisecond enable pulse; keeps the persistence counters narrow
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tick_cnt_reg <= 32'h0000_0000;
    else if (tick)
      tick_cnt_reg <= 32'h0000_0000;
    else
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
  end
  assign tick = (tick_cnt_reg == 32'(TICK_CYC - 1));

  // Any break in the condition restarts the count; nominal times, no tolerance used
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ais_state_reg <= AIS_IDLE;
      ais_cnt_reg   <= '0;
    end
    else
    begin
      case (ais_state_reg)
        AIS_IDLE:
        begin
          if (!aisv_defect_decl)
            ais_cnt_reg <= '0;
          else if (tick && (ais_cnt_reg == AIS_TICK_W'(SET_TICKS - 1)))
          begin
            ais_state_reg <= AIS_FAIL;
            ais_cnt_reg   <= '0;
          end
          else if (tick)
            ais_cnt_reg <= ais_cnt_reg + AIS_TICK_W'(1);
        end
        AIS_FAIL:
        begin
          if (aisv_defect_decl)
            ais_cnt_reg <= '0;
          else if (tick && (ais_cnt_reg == AIS_TICK_W'(CLR_TICKS - 1)))
          begin
            ais_state_reg <= AIS_IDLE;
            ais_cnt_reg   <= '0;
          end
          else if (tick)
            ais_cnt_reg <= ais_cnt_reg + AIS_TICK_W'(1);
        end
        default:
        begin
          ais_state_reg <= AIS_IDLE;
          ais_cnt_reg   <= '0;
        end
      endcase
    end
  end
  assign aisv_failure = (ais_state_reg == AIS_FAIL);

  // ----------------------------------------------------------------
  // Composite VT error event
  // ----------------------------------------------------------------
  // Registered so the flag is glitch free toward the flag register outside
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      vt_error_event <= 1'b0;
    else
      vt_error_event <= mask_reg[MB_CHAN_EN] & (
                          (size_err_decl    & mask_reg[MB_SIZE])
                        | (lopv_decl        & mask_reg[MB_LOPV])
                        | (label_chg_decl   & mask_reg[MB_LABEL])
                        | (aisv_failure     & mask_reg[MB_AIS_FAIL_EN])
                        | (aisv_defect_decl & mask_reg[MB_AIS_DEF])
                        | ovf_reg | rfiv_cause_masked | rdiv_cause_masked
                        | aps_chg_cause_masked);
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_read_bip_hi;
    rd_take && (s_axi_araddr == OFF_BIP_HI);
  endsequence
  sequence s_read_rei_lo;
    rd_take && (s_axi_araddr == OFF_REI_LO);
  endsequence

  property p_ptr_inc_count;
    ptr_inc_evt && !(rd_take && s_axi_araddr == OFF_BIP_HI) && (inc_cnt != 4'hF)
      |=> inc_cnt == $past(inc_cnt) + 4'h1;
  endproperty
  a_ptr_inc_count: assert property (p_ptr_inc_count)
    else $error("pointer increment count did not step");

  property p_bip_hi_layout;
    s_read_bip_hi |=> s_axi_rvalid && (s_axi_rdata[7:0] == {$past(inc_cnt), $past(bip_cnt[11:8])});
  endproperty
  a_bip_hi_layout: assert property (p_bip_hi_layout)
    else $error("BIP high byte read data wrong");

  // Guarded against a same-cycle event, which would land in the new interval
  property p_bip_hi_clear;
    s_read_bip_hi ##0 !bip2_err_evt ##0 !ptr_inc_evt
      |=> (bip_cnt[11:8] == 4'h0) && (inc_cnt == 4'h0);
  endproperty
  a_bip_hi_clear: assert property (p_bip_hi_clear)
    else $error("BIP high byte not cleared on read");

  property p_dec_clear;
    rd_take && (s_axi_araddr == OFF_REI_HI) && !ptr_dec_evt |=> dec_cnt == 4'h0;
  endproperty
  a_dec_clear: assert property (p_dec_clear)
    else $error("pointer decrement nibble not cleared on read");

  property p_rei_lo_data;
    s_read_rei_lo |=> s_axi_rdata[7:0] == $past(rei_cnt[7:0]);
  endproperty
  a_rei_lo_data: assert property (p_rei_lo_data)
    else $error("REI low byte read data wrong");

  property p_rei_lo_clear;
    s_read_rei_lo ##0 !rei_evt
      |=> (rei_cnt[7:0] == 8'h00) && (rei_cnt[11:8] == $past(rei_cnt[11:8]));
  endproperty
  a_rei_lo_clear: assert property (p_rei_lo_clear)
    else $error("REI low byte clear disturbed other bits");

  property p_chan_disable;
    !mask_reg[MB_CHAN_EN] |=> !vt_error_event;
  endproperty
  a_chan_disable: assert property (p_chan_disable)
    else $error("composite event raised with channel disabled");

  property p_ovf_cause;
    mask_reg[MB_CHAN_EN] && ovf_reg |=> vt_error_event;
  endproperty
  a_ovf_cause: assert property (p_ovf_cause)
    else $error("overflow did not raise composite event");

  property p_mask_reset;
    $rose(aresetn) |-> mask_view == 8'h00;
  endproperty
  a_mask_reset: assert property (p_mask_reset)
    else $error("mask register not zero after reset");

  property p_size_cause;
    mask_reg[MB_CHAN_EN] && mask_reg[MB_SIZE] && size_err_decl |=> vt_error_event;
  endproperty
  a_size_cause: assert property (p_size_cause)
    else $error("size error did not raise composite event");

  property p_ovf_latch;
    es_overflow_evt |=> ovf_reg;
  endproperty
  a_ovf_latch: assert property (p_ovf_latch)
    else $error("overflow bit not latched");

  // Only a write of one may drop the latch
  property p_ovf_hold;
    ovf_reg && !(mask_wr && w_data_reg[MB_OVF]) |=> ovf_reg;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold)
    else $error("overflow bit dropped without a clear");

  property p_ais_rise;
    $rose(aisv_failure) |-> $past(aisv_defect_decl) && $past(tick);
  endproperty
  a_ais_rise: assert property (p_ais_rise)
    else $error("AIS-V failure declared without defect");

  property p_bip_saturate;
    (bip_cnt == 12'hFFF) && !rd_take |=> bip_cnt == 12'hFFF;
  endproperty
  a_bip_saturate: assert property (p_bip_saturate)
    else $error("BIP count wrapped past maximum");

endmodule : vtpc_regs
`default_nettype wire

// ==== vtpc_evt_src.sv ====
// Behavioural upstream pointer interpreter that emits VT stream events
`timescale 1ns/1ps
`default_nettype none
module vtpc_evt_src
  import vtpc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        go,
  input  wire logic [1:0]  sel,
  input  wire logic [11:0] num,
  input  wire logic        slow,
  output var  logic        busy,
  output var  logic [3:0]  evt
);
  // ------------------------------------------------
  // Event burst generator
  // ------------------------------------------------
  logic [11:0] left;
  logic [1:0]  sel_r;
  logic        ph;

  // Slow mode leaves an idle cycle between events
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      left  <= 12'h000;
      sel_r <= 2'h0;
      ph    <= 1'b0;
      evt   <= 4'h0;
    end
    else
    begin
      ph  <= slow ? ~ph : 1'b0;
      evt <= 4'h0;
      if (go)
      begin
        left  <= num;
        sel_r <= sel;
      end
      else if (left != 12'h000 && !ph)
      begin
        evt[sel_r] <= 1'b1;
        left       <= left - 12'h001;
      end
    end
  end

  // Busy until the last pulse has been presented
  assign busy = (left != 12'h000) || (evt != 4'h0);
endmodule : vtpc_evt_src
`default_nettype wire

// ==== tb_vt_demap_perf_counters_events.sv ====
// Self-checking bench for the VT de-mapper counter and event mask bank
`timescale 1ns/1ps
`default_nettype none
module tb_vt_demap_perf_counters_events
  import vtpc_pkg::*;
;
  // ------------------------------------------------
  // Signals
  // ------------------------------------------------
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [6:0]  c = 7'h00;
  logic        es_overflow_evt = 1'b0, vt_error_event, aisv_failure;
  logic        go = 1'b0, slow = 1'b0, busy;
  logic [1:0]  sel = 2'h0;
  logic [11:0] num = 12'h000;
  logic [3:0]  evt;
  logic [31:0] d;
  logic [1:0]  r;
  logic [7:0]  cb;
  int          n_fail = 0, total_checks = 0, i, k;
  int          mb[4] = '{MB_SIZE, MB_LOPV, MB_LABEL, MB_AIS_DEF};

  // Clock at 10 MHz
  always #50 aclk = ~aclk;

  vtpc_evt_src SRC (.aclk, .aresetn, .go, .sel, .num, .slow, .busy, .evt);

  vtpc_regs #(.TICK_CYC(4), .SET_TICKS(8), .CLR_TICKS(12)) DUT (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bip2_err_evt(evt[0]),
    .rei_evt(evt[1]), .ptr_inc_evt(evt[2]), .ptr_dec_evt(evt[3]),
    .size_err_decl(c[0]), .lopv_decl(c[1]), .label_chg_decl(c[2]),
    .aisv_defect_decl(c[3]), .es_overflow_evt, .rfiv_cause_masked(c[4]),
    .rdiv_cause_masked(c[5]), .aps_chg_cause_masked(c[6]), .vt_error_event,
    .aisv_failure);

  // ------------------------------------------------
  // Bench tasks
  // ------------------------------------------------
  task automatic stop_test;
    if (n_fail == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  // A wait that runs out is a mismatch
  task automatic tmo;
    n_fail++;
    stop_test;
  endtask : tmo

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (k = 0; k < 40; k++)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1)
        break;
    end
    if (k == 40) tmo;
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, RESP_OKAY});
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (k = 0; k < 40; k++)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
        break;
    end
    if (k == 40) tmo;
    v  = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  // Burst of one event kind from the upstream model
  task automatic emit(input logic [1:0] s, input logic [11:0] n, input logic sl);
    @(posedge aclk);
    go   <= 1'b1;
    sel  <= s;
    num  <= n;
    slow <= sl;
    @(posedge aclk);
    go <= 1'b0;
    for (k = 0; k < 9000; k++)
    begin
      @(posedge aclk);
      if (busy === 1'b0)
        break;
    end
    if (k == 9000) tmo;
  endtask : emit

  // ------------------------------------------------
  // Test sequence
  // ------------------------------------------------
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 5; i++)
    begin
      rd(8'(i * 4), d, r);
      chk("reset value", d, 32'h0);
      chk("rresp", {30'h0, r}, {30'h0, RESP_OKAY});
    end
    rd(8'h14, d, r);
    chk("unmapped resp", {30'h0, r}, {30'h0, RESP_SLVERR});
    chk("unmapped data", d, 32'h0);
    emit(2'd0, 12'd300, 1'b0);
    emit(2'd2, 12'd5, 1'b1);
    rd(OFF_BIP_HI, d, r);
    chk("bip hi", d, 32'h51);
    rd(OFF_BIP_LO, d, r);
    chk("bip lo", d, 32'h2C);
    emit(2'd1, 12'd291, 1'b1);
    emit(2'd3, 12'd3, 1'b0);
    rd(OFF_REI_HI, d, r);
    chk("rei hi", d, 32'h31);
    rd(OFF_REI_LO, d, r);
    chk("rei lo", d, 32'h23);
    // Second pass: every byte cleared by its own read
    for (i = 0; i < 4; i++)
    begin
      rd(8'(i * 4), d, r);
      chk("cleared byte", d, 32'h0);
    end
    // Overrun every counter to its ceiling
    emit(2'd0, 12'd4095, 1'b0);
    emit(2'd0, 12'd5, 1'b0);
    emit(2'd1, 12'd4095, 1'b0);
    emit(2'd1, 12'd9, 1'b0);
    emit(2'd2, 12'd17, 1'b0);
    emit(2'd3, 12'd20, 1'b0);
    for (i = 0; i < 4; i++)
    begin
      rd(8'(i * 4), d, r);
      chk("saturated byte", d, 32'hFF);
    end
    wr(OFF_MASK, 8'hFF);
    rd(OFF_MASK, d, r);
    chk("mask rw bits", d, 32'hF5);
    // Each cause with channel off, its mask off, then both on
    for (i = 0; i < 7; i++)
    begin
      for (int m = 0; m < 3; m++)
      begin
        cb = (i < 4) ? (8'h01 << mb[i]) : 8'h00;
        wr(OFF_MASK, (m == 0) ? cb : (m == 1) ? 8'h80 : (8'h80 | cb));
        c <= 7'h01 << i;
        repeat (3) @(posedge aclk);
        chk("composite", {31'h0, vt_error_event}, 32'(m == 2 || (m == 1 && i > 3)));
        c <= 7'h00;
        repeat (3) @(posedge aclk);
      end
    end
    wr(OFF_MASK, 8'h80);
    es_overflow_evt <= 1'b1;
    @(posedge aclk);
    es_overflow_evt <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("ovf flag", {31'h0, vt_error_event}, 32'h1);
    rd(OFF_MASK, d, r);
    chk("ovf latched", d, 32'h88);
    wr(OFF_MASK, 8'h88);
    rd(OFF_MASK, d, r);
    chk("ovf cleared", d, 32'h80);
    wr(OFF_MASK, 8'h84);
    c <= 7'h08;
    repeat (24) @(posedge aclk);
    chk("ais early", {31'h0, aisv_failure}, 32'h0);
    for (k = 0; k < 20 && aisv_failure !== 1'b1; k++) @(posedge aclk);
    if (k == 20) tmo;
    repeat (3) @(posedge aclk);
    chk("ais flag", {31'h0, vt_error_event}, 32'h1);
    rd(OFF_MASK, d, r);
    chk("ais status", d, 32'h86);
    c <= 7'h00;
    repeat (40) @(posedge aclk);
    chk("ais held", {31'h0, aisv_failure}, 32'h1);
    for (k = 0; k < 20 && aisv_failure !== 1'b0; k++) @(posedge aclk);
    if (k == 20) tmo;
    stop_test;
  end
endmodule : tb_vt_demap_perf_counters_events
`default_nettype wire
